/* bench/acc_host_model.sv */
// acc_host_model.sv: host side of the coefficient register port and the calibration write port.
// assumes: the bench calls access(); every change lands on a falling edge of clk_sys.
`timescale 1ns/10ps

module acc_host_model (
   // clock
   input  wire logic        clk_sys,
   // host register port
   output      logic        reg_wr_en,
   output      logic        reg_rd_en,
   output      logic [7:0]  reg_addr,
   output      logic [23:0] reg_wdata,
   input  wire logic [23:0] reg_rdata_q,
   // calibration engine write port
   output      logic        cal_wr_en,
   output      logic [7:0]  cal_addr,
   output      logic [23:0] cal_wdata
);
   // ----------------------------------------
   // idle bus at time zero
   // ----------------------------------------
   initial begin
      {reg_wr_en, reg_rd_en, cal_wr_en} = 3'h0;
      {reg_addr, cal_addr, reg_wdata, cal_wdata} = 64'h0;
   end

   // ----------------------------------------
   // one strobe cycle, answer taken at the next falling edge
   // ----------------------------------------
   task automatic access(input logic wr, input logic rd, input logic cal, input logic [7:0] addr,
                         input logic [23:0] hdat, input logic [23:0] cdat, output logic [23:0] rdat);
      @(negedge clk_sys);
      {reg_wr_en, reg_rd_en, cal_wr_en} = {wr, rd, cal};
      {reg_addr, cal_addr, reg_wdata, cal_wdata} = {addr, addr, hdat, cdat};
      @(negedge clk_sys);
      rdat = reg_rdata_q;
      {reg_wr_en, reg_rd_en, cal_wr_en} = 3'h0;
      // released data lines show the inverse, so a stale copy never passes
      {reg_wdata, cal_wdata} = {~hdat, ~cdat};
   endtask : access
endmodule : acc_host_model

/* bench/adc_calibration_correction_bench.sv */
// adc_calibration_correction_bench.sv: self-checking bench of the calibration corrector.
// assumes: acc_pkg and acc_params.svh compiled first; the host model drives the register ports.
`timescale 1ns/10ps
`include "acc_params.svh"

module adc_calibration_correction_bench;
   import acc_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clk_sys;                     // 25 MHz
   logic        srst;                        // synchronous, active high
   logic        reg_wr_en, reg_rd_en, cal_wr_en;
   logic [7:0]  reg_addr, cal_addr;
   logic [23:0] reg_wdata, reg_rdata_q, cal_wdata;
   logic        self_offset_disable, polarity_mode_select, conv_valid, res_valid_q;
   logic [15:0] result_coefficient_selection;
   logic [2:0]  active_gain_sel, conv_dest, res_dest_q;
   acc_word_t   conv_data, res_data_q;
   logic [23:0] sh [13];                     // shadow of offsets 0x13..0x1f
   logic [26:0] exp_q [$];                   // notes of {dest, data}
   logic [31:0] rs = 32'h112e_d0d6;          // xorshift state
   int          fail_count = 0;
   int          cmp_count  = 0;

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   acc_core i_acc_core (
      .clk_sys(clk_sys), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .cal_wr_en(cal_wr_en), .cal_addr(cal_addr),
      .cal_wdata(cal_wdata), .self_offset_disable(self_offset_disable),
      .polarity_mode_select(polarity_mode_select), .result_coefficient_selection(result_coefficient_selection),
      .active_gain_sel(active_gain_sel), .conv_valid(conv_valid), .conv_data(conv_data),
      .conv_dest(conv_dest), .res_valid_q(res_valid_q), .res_data_q(res_data_q), .res_dest_q(res_dest_q));

   acc_host_model i_acc_host_model (
      .clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .cal_wr_en(cal_wr_en), .cal_addr(cal_addr),
      .cal_wdata(cal_wdata));

   // ----------------------------------------
   // reference arithmetic
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   function automatic logic signed [49:0] ex(input logic [23:0] a);
      return $signed({{26{a[23]}}, a});
   endfunction : ex

   // clamp instead of wrap
   function automatic logic [23:0] sat(input logic signed [49:0] v);
      if (v > 50'sh7f_ffff) return 24'h7f_ffff;
      if (v < -50'sh80_0000) return 24'h80_0000;
      return v[23:0];
   endfunction : sat

   // gain is unsigned, msb weighs one; floor of the product
   function automatic logic [23:0] mulg(input logic [23:0] v, input logic [23:0] g);
      logic signed [49:0] p;
      p = ex(v) * $signed({26'h0, g});
      return sat(p >>> 23);
   endfunction : mulg

   // controls and shadow must stay put while a result is in flight
   function automatic logic [23:0] model(input logic [23:0] d, input logic [2:0] dst);
      logic [23:0] s;
      logic [1:0]  c;
      s = self_offset_disable ? d : sat(ex(d) - ex(sh[4]));
      s = mulg(s, sh[5 + active_gain_sel]);
      c = result_coefficient_selection[2*dst +: 2];
      if (c < 2'h2) s = mulg(sat(ex(s) - ex(sh[c])), sh[2 + c]);
      if (polarity_mode_select) s = sat(ex(s) <<< 1);
      return s;
   endfunction : model

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [26:0] got, input logic [26:0] want);
      cmp_count++;
      if (got !== want) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk

   task automatic put(input logic cal, input logic [7:0] a, input logic [23:0] v);
      logic [23:0] r;
      i_acc_host_model.access(!cal, 1'b0, cal, a, v, v, r);
      if (a >= 8'h13 && a <= 8'h1f) sh[a - 8'h13] = v;
   endtask : put

   task automatic get(input logic [7:0] a, input logic [23:0] want);
      logic [23:0] r;
      i_acc_host_model.access(1'b0, 1'b1, 1'b0, a, 24'h0, 24'h0, r);
      chk({3'h0, r}, {3'h0, want});
   endtask : get

   task automatic conv(input logic [23:0] d, input logic [2:0] dst);
      @(negedge clk_sys);
      {conv_valid, conv_data, conv_dest} = {1'b1, d, dst};
      exp_q.push_back({dst, model(d, dst)});
   endtask : conv

   // results come back in order, oldest note first
   always @(negedge clk_sys) begin
      if (res_valid_q === 1'b1) begin
         if (exp_q.size() > 0) begin
            chk({res_dest_q, res_data_q}, exp_q.pop_front());
         end else begin
            // a result nobody asked for is a fault, even when it is unknown
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, {res_dest_q, res_data_q}, 27'h0);
         end
      end
   end

   task automatic conclude();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   // hang guard, about five times the expected run
   initial begin
      repeat (6000) @(posedge clk_sys);
      fail_count++;
      $display("watchdog expired at %0t", $time);
      conclude();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] v;
      logic [23:0] r;
      {srst, conv_valid, conv_data, conv_dest} = {1'b1, 1'b0, 24'h0, 3'h0};
      {self_offset_disable, polarity_mode_select, active_gain_sel, result_coefficient_selection} = 21'h0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      srst = 1'b0;
      // reset values of the table, zero on unmapped places
      for (int a = 8'h12; a <= 8'h20; a++) begin
         v[23:0] = (a == 8'h15 || a == 8'h16 || (a >= 8'h18 && a <= 8'h1f)) ? `ACC_RST_GAIN : `ACC_RST_OFFSET;
         if (a < 8'h13 || a > 8'h1f) v[23:0] = `ACC_RST_RDATA;
         else sh[a - 8'h13] = v[23:0];
         get(8'(a), v[23:0]);
      end
      put(1'b0, 8'h20, 24'h12_3456);
      get(8'h20, 24'h00_0000);
      // read and write together return the old word
      i_acc_host_model.access(1'b1, 1'b1, 1'b0, 8'h15, 24'h35_5aa5, 24'h0, r);
      chk({3'h0, r}, {3'h0, sh[2]});
      sh[2] = 24'h35_5aa5;
      get(8'h15, sh[2]);
      // calibration beats a host write in the same cycle
      i_acc_host_model.access(1'b1, 1'b0, 1'b1, 8'h16, 24'h11_1111, 24'h22_2222, r);
      sh[3] = 24'h22_2222;
      get(8'h16, sh[3]);
      put(1'b1, 8'h17, 24'hff_fff0);
      get(8'h17, 24'hff_fff0);
      // self offset of minus one must lift a zero input to plus one
      put(1'b0, 8'h17, 24'hff_ffff);
      conv(24'h00_0000, 3'h0);
      @(negedge clk_sys);
      conv_valid = 1'b0;
      repeat (6) @(negedge clk_sys);
      // random coefficients and controls, full-scale inputs in every batch
      for (int b = 0; b < 24; b++) begin
         for (int i = 0; i < 13; i++) begin
            v = rnd();
            if (i == 0 || i == 1 || i == 4) v[23:0] = {{5{v[18]}}, v[18:0]};
            put(v[31], 8'(19 + i), v[23:0]);
         end
         get(8'(19 + b % 13), sh[b % 13]);
         v = rnd();
         @(negedge clk_sys);
         {self_offset_disable, polarity_mode_select, active_gain_sel, result_coefficient_selection} = v[20:0];
         for (int i = 0; i < 8; i++) conv(i == 0 ? 24'h7f_ffff : i == 1 ? 24'h80_0000 : 24'(rnd()), 3'(i));
         @(negedge clk_sys);
         {conv_valid, conv_data} = {1'b0, ~conv_data};
         repeat (7) @(negedge clk_sys);
      end
      chk(27'(exp_q.size()), 27'h0);
      conclude();
   end
endmodule : adc_calibration_correction_bench

/* common/acc_params.svh */
// acc_params.svh: offsets, reset values and datapath figures of the calibration corrector.
// assumes: included by bare name from the package and the bench.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ----------------------------------------
// register offsets (serial control port)
// ----------------------------------------
`define ACC_ADDR_SYSTEM_OFFSET_A      8'h13
`define ACC_ADDR_SYSTEM_OFFSET_B      8'h14
`define ACC_ADDR_SCALE_A        8'h15
`define ACC_ADDR_SCALE_B        8'h16
`define ACC_ADDR_SELF_OFF       8'h17
`define ACC_ADDR_SELF_GAIN_BASE 8'h18
`define ACC_ADDR_SELF_GAIN_LAST 8'h1F

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACC_RST_OFFSET          24'h00_0000
`define ACC_RST_GAIN            24'h80_0000
`define ACC_RST_RDATA           24'h00_0000

// ----------------------------------------
// datapath figures
// ----------------------------------------
`define ACC_WORD_W              24
`define ACC_FRAC_BITS           23
`define ACC_GAIN_SETTINGS       8
`define ACC_DEST_COUNT          8
`define ACC_PIPE_LAT            5

`endif

/* common/acc_pkg.sv */
// acc_pkg.sv: types shared by the calibration corrector files.
// assumes: acc_params.svh is on the include path.
`include "acc_params.svh"

package acc_pkg;
   // signed result word, two's complement
   typedef logic signed [`ACC_WORD_W-1:0] acc_word_t;
   // unsigned fixed-point gain word, msb weighs one
   typedef logic [`ACC_WORD_W-1:0] acc_gain_t;
   // per-result system coefficient choice
   typedef enum logic [1:0] {
      ACC_SEL_A     = 2'b00,
      ACC_SEL_B     = 2'b01,
      ACC_SEL_OFF_0 = 2'b10,
      ACC_SEL_OFF_1 = 2'b11
   } acc_sel_t;
endpackage : acc_pkg

/* verilog/acc_core.sv */
// acc_core.sv: calibration correction of raw conversion results plus its coefficient registers.
// assumes: one 25 MHz clock, synchronous active-high reset, a simple register port and a
// calibration engine outside that overwrites coefficients through its own write port.
`timescale 1ns/10ps

module acc_core
   import acc_pkg::*;
#(
   parameter int GAIN_SETTINGS = `ACC_GAIN_SETTINGS,
   parameter int DEST_COUNT    = `ACC_DEST_COUNT
) (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           srst,
   // register port
   input  wire logic                           reg_wr_en,
   input  wire logic                           reg_rd_en,
   input  wire logic [7:0]                     reg_addr,
   input  wire logic [`ACC_WORD_W-1:0]         reg_wdata,
   output      logic [`ACC_WORD_W-1:0]         reg_rdata_q,
   // on-demand calibration write port
   input  wire logic                           cal_wr_en,
   input  wire logic [7:0]                     cal_addr,
   input  wire logic [`ACC_WORD_W-1:0]         cal_wdata,
   // control bits
   input  wire logic                           self_offset_disable,
   input  wire logic                           polarity_mode_select,
   input  wire logic [2*DEST_COUNT-1:0]        result_coefficient_selection,
   input  wire logic [$clog2(GAIN_SETTINGS)-1:0] active_gain_sel,
   // raw conversion in
   input  wire logic                           conv_valid,
   input  wire acc_pkg::acc_word_t             conv_data,
   input  wire logic [$clog2(DEST_COUNT)-1:0]  conv_dest,
   // corrected result out
   output      logic                           res_valid_q,
   output      acc_pkg::acc_word_t             res_data_q,
   output      logic [$clog2(DEST_COUNT)-1:0]  res_dest_q
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // a single destination would leave the destination index zero bits wide
   if (GAIN_SETTINGS != 8 || DEST_COUNT < 2 || DEST_COUNT > 8) begin : g_bad
      $error("acc_core: eight gain settings and two to eight destinations are served");
   end

   localparam int GI_W = $clog2(GAIN_SETTINGS);
   localparam int DI_W = $clog2(DEST_COUNT);

   // clamp a wide signed value into the result word
   function automatic acc_word_t acc_sat(input logic signed [25:0] v);
      if (v > 26'sh07F_FFFF) begin
         acc_sat = 24'h7F_FFFF;
      end else if (v < -26'sh080_0000) begin
         acc_sat = 24'h80_0000;
      end else begin
         acc_sat = v[23:0];
      end
   endfunction : acc_sat

   // ----------------------------------------
   // coefficient registers
   // ----------------------------------------
   acc_word_t off_a_q, off_a_d;                  // system offset a, signed
   acc_word_t off_b_q, off_b_d;                  // system offset b, signed
   acc_gain_t scale_a_q, scale_a_d;              // system scale a
   acc_gain_t scale_b_q, scale_b_d;              // system scale b
   acc_word_t selfoff_q, selfoff_d;              // self offset, always signed
   acc_gain_t selfgain_q [GAIN_SETTINGS];        // one self gain per amplifier setting
   acc_gain_t selfgain_d [GAIN_SETTINGS];
   logic [`ACC_WORD_W-1:0] reg_rdata_d;          // read answer

   // host write first, calibration write after so it wins a same-cycle clash
   always_comb begin
      off_a_d     = off_a_q;
      off_b_d     = off_b_q;
      scale_a_d   = scale_a_q;
      scale_b_d   = scale_b_q;
      selfoff_d   = selfoff_q;
      selfgain_d  = selfgain_q;
      reg_rdata_d = reg_rdata_q;
      // software write, value stays until the next write
      if (reg_wr_en) begin
         case (reg_addr)
            `ACC_ADDR_SYSTEM_OFFSET_A: off_a_d   = reg_wdata;
            `ACC_ADDR_SYSTEM_OFFSET_B: off_b_d   = reg_wdata;
            `ACC_ADDR_SCALE_A:   scale_a_d = reg_wdata;
            `ACC_ADDR_SCALE_B:   scale_b_d = reg_wdata;
            `ACC_ADDR_SELF_OFF:  selfoff_d = reg_wdata;
            default: begin
               if (reg_addr >= `ACC_ADDR_SELF_GAIN_BASE && reg_addr <= `ACC_ADDR_SELF_GAIN_LAST) begin
                  selfgain_d[GI_W'(reg_addr - `ACC_ADDR_SELF_GAIN_BASE)] = reg_wdata;
               end
            end
         endcase
      end
      // calibration run overwrites the stored value
      if (cal_wr_en) begin
         case (cal_addr)
            `ACC_ADDR_SYSTEM_OFFSET_A: off_a_d   = cal_wdata;
            `ACC_ADDR_SYSTEM_OFFSET_B: off_b_d   = cal_wdata;
            `ACC_ADDR_SCALE_A:   scale_a_d = cal_wdata;
            `ACC_ADDR_SCALE_B:   scale_b_d = cal_wdata;
            `ACC_ADDR_SELF_OFF:  selfoff_d = cal_wdata;
            default: begin
               if (cal_addr >= `ACC_ADDR_SELF_GAIN_BASE && cal_addr <= `ACC_ADDR_SELF_GAIN_LAST) begin
                  selfgain_d[GI_W'(cal_addr - `ACC_ADDR_SELF_GAIN_BASE)] = cal_wdata;
               end
            end
         endcase
      end
      // read shows stored value, unmapped offsets read zero
      if (reg_rd_en) begin
         case (reg_addr)
            `ACC_ADDR_SYSTEM_OFFSET_A: reg_rdata_d = off_a_q;
            `ACC_ADDR_SYSTEM_OFFSET_B: reg_rdata_d = off_b_q;
            `ACC_ADDR_SCALE_A:   reg_rdata_d = scale_a_q;
            `ACC_ADDR_SCALE_B:   reg_rdata_d = scale_b_q;
            `ACC_ADDR_SELF_OFF:  reg_rdata_d = selfoff_q;
            default: begin
               if (reg_addr >= `ACC_ADDR_SELF_GAIN_BASE && reg_addr <= `ACC_ADDR_SELF_GAIN_LAST) begin
                  reg_rdata_d = selfgain_q[GI_W'(reg_addr - `ACC_ADDR_SELF_GAIN_BASE)];
               end else begin
                  reg_rdata_d = `ACC_RST_RDATA;
               end
            end
         endcase
      end
   end

   // register the coefficients
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         off_a_q     <= `ACC_RST_OFFSET;
         off_b_q     <= `ACC_RST_OFFSET;
         scale_a_q   <= `ACC_RST_GAIN;
         scale_b_q   <= `ACC_RST_GAIN;
         selfoff_q   <= `ACC_RST_OFFSET;
         reg_rdata_q <= `ACC_RST_RDATA;
         for (int i = 0; i < GAIN_SETTINGS; i++) begin
            selfgain_q[i] <= `ACC_RST_GAIN;
         end
      end else begin
         off_a_q     <= off_a_d;
         off_b_q     <= off_b_d;
         scale_a_q   <= scale_a_d;
         scale_b_q   <= scale_b_d;
         selfoff_q   <= selfoff_d;
         reg_rdata_q <= reg_rdata_d;
         selfgain_q  <= selfgain_d;
      end
   end

   // ----------------------------------------
   // correction pipeline
   // ----------------------------------------
   logic [4:0] v_q, v_d;                         // stage valids, bit 4 is the output
   acc_word_t  s1_q, s1_d, s2_q, s2_d;           // after self offset, after self gain
   acc_word_t  s3_q, s3_d, s4_q, s4_d;           // after system offset, after system gain
   acc_word_t  res_d;
   logic [GI_W-1:0] gi1_q, gi1_d;                // gain setting in force for the result
   logic [DI_W-1:0] d1_q, d2_q, d3_q, d4_q;      // destination carried along
   logic [DI_W-1:0] d1_d, d2_d, d3_d, d4_d, dres_d;
   acc_sel_t   sel3_q, sel3_d;                   // choice carried into the gain stage
   acc_sel_t   sel2;                             // choice looked up for stage three
   acc_word_t  self_scaled, sys_scaled;          // multiplier outputs
   acc_gain_t  sys_gain;                         // scale a or b

   // self gain stage, unsigned gain
   acc_scale #(.IN_W(`ACC_WORD_W), .G_W(`ACC_WORD_W), .FRAC(`ACC_FRAC_BITS)) u_self_scale (
      .value  (s1_q),
      .gain   (selfgain_q[gi1_q]),
      .scaled (self_scaled)
   );

   // system gain stage, reaches 1.999999881x at most
   acc_scale #(.IN_W(`ACC_WORD_W), .G_W(`ACC_WORD_W), .FRAC(`ACC_FRAC_BITS)) u_sys_scale (
      .value  (s3_q),
      .gain   (sys_gain),
      .scaled (sys_scaled)
   );

   // next values of every stage
   always_comb begin
      sel2     = acc_sel_t'(result_coefficient_selection[2*d2_q +: 2]);
      sys_gain = (sel3_q == ACC_SEL_B) ? scale_b_q : scale_a_q;
      v_d      = {v_q[3:0], conv_valid};
      // stage 1: self offset first, signed, skipped when disabled
      s1_d     = self_offset_disable ? conv_data
                                     : acc_sat(26'(conv_data) - 26'(selfoff_q));
      gi1_d    = active_gain_sel;
      d1_d     = conv_dest;
      // stage 2: self gain, clamped inside the multiplier
      s2_d     = self_scaled;
      d2_d     = d1_q;
      // stage 3: system offset a or b, self-only codes pass through
      case (sel2)
         ACC_SEL_A: s3_d = acc_sat(26'(s2_q) - 26'(off_a_q));
         ACC_SEL_B: s3_d = acc_sat(26'(s2_q) - 26'(off_b_q));
         default:   s3_d = s2_q;
      endcase
      sel3_d   = sel2;
      d3_d     = d2_q;
      // stage 4: system gain, unsigned, skipped for self-only codes
      s4_d     = (sel3_q[1] == 1'b0) ? sys_scaled : s3_q;
      d4_d     = d3_q;
      // stage 5: unipolar doubling comes last, clamped
      res_d    = polarity_mode_select ? acc_sat(26'(s4_q) <<< 1) : s4_q;
      dres_d   = d4_q;
   end

   // register the stages; inner data flops carry no reset, only valids and the output data and destination do
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         v_q <= 5'h0;
      end else begin
         v_q <= v_d;
      end
      s1_q       <= s1_d;
      gi1_q      <= gi1_d;
      d1_q       <= d1_d;
      s2_q       <= s2_d;
      d2_q       <= d2_d;
      s3_q       <= s3_d;
      sel3_q     <= sel3_d;
      d3_q       <= d3_d;
      s4_q       <= s4_d;
      d4_q       <= d4_d;
      if (srst) begin
         res_data_q <= 24'h00_0000;
         res_dest_q <= '0;
      end else begin
         res_data_q <= res_d;
         res_dest_q <= dres_d;
      end
   end

   assign res_valid_q = v_q[4];

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   pipe_latency_a: assert property (conv_valid |-> ##5 res_valid_q)
      else $error("result did not appear five cycles after input");
   self_off_skip_a: assert property (conv_valid && self_offset_disable |=> s1_q == $past(conv_data))
      else $error("self offset applied while disabled");
   self_off_sub_a: assert property (conv_valid && !self_offset_disable && selfoff_q == 24'hFF_FFFF
      && conv_data == 24'h00_0000 |=> s1_q == 24'h00_0001)
      else $error("self offset not treated as signed");
   sys_bypass_a: assert property (v_q[2] && sel3_q[1] |=> s4_q == $past(s3_q))
      else $error("system gain applied to a self-only result");
   gain_unsigned_a: assert property (v_q[0] && s1_q > 0 |=> s2_q >= 0)
      else $error("gain turned a positive value negative");
   host_write_a: assert property (reg_wr_en && !cal_wr_en && reg_addr == `ACC_ADDR_SCALE_A
      |=> scale_a_q == $past(reg_wdata))
      else $error("scale a write not stored");
   cal_wins_a: assert property (cal_wr_en && cal_addr == `ACC_ADDR_SELF_OFF
      |=> selfoff_q == $past(cal_wdata))
      else $error("calibration value did not overwrite self offset");
   unity_pass_a: assert property (v_q[0] && selfgain_q[gi1_q] == `ACC_RST_GAIN
      |=> s2_q == $past(s1_q))
      else $error("unity self gain changed the value");
   clamp_top_a: assert property (v_q[0] && s1_q == 24'h7F_FFFF && selfgain_q[gi1_q] > `ACC_RST_GAIN
      |=> s2_q == 24'h7F_FFFF)
      else $error("overflow wrapped instead of clamping");

   sel_a_cov:   cover property (v_q[2] && sel3_q == ACC_SEL_A);
   sel_b_cov:   cover property (v_q[2] && sel3_q == ACC_SEL_B);
   unipol_cov:  cover property (v_q[3] && polarity_mode_select);
endmodule : acc_core

/* verilog/acc_scale.sv */
// acc_scale.sv: signed value times unsigned fixed-point gain, clamped to the value width.
// assumes: gain msb weighs one, lsb weighs two to the minus FRAC; purely combinational.
`timescale 1ns/10ps

module acc_scale #(
   parameter int IN_W = 24,
   parameter int G_W  = 24,
   parameter int FRAC = 23
) (
   // operands
   input  wire logic signed [IN_W-1:0] value,
   input  wire logic        [G_W-1:0]  gain,
   // clamped product
   output      logic signed [IN_W-1:0] scaled
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (FRAC >= G_W || IN_W < 2) begin : g_bad
      $error("acc_scale: FRAC must be below G_W and IN_W at least 2");
   end

   localparam int P_W = IN_W + G_W + 1;

   logic signed [P_W-1:0] prod;      // full product
   logic signed [P_W-1:0] shifted;   // binary point removed
   logic signed [P_W-1:0] max_v;     // positive full scale
   logic signed [P_W-1:0] min_v;     // negative full scale

   // ----------------------------------------
   // multiply and clamp
   // ----------------------------------------
   always_comb begin
      // gain padded with a zero so it can never turn negative
      prod    = P_W'(value) * $signed({1'b0, gain});
      shifted = prod >>> FRAC;
      max_v   = P_W'({1'b0, {(IN_W-1){1'b1}}});
      min_v   = -max_v - P_W'(1);
      // clamp rather than wrap, a wrapped code flips sign
      if (shifted > max_v) begin
         scaled = {1'b0, {(IN_W-1){1'b1}}};
      end else if (shifted < min_v) begin
         scaled = {1'b1, {(IN_W-1){1'b0}}};
      end else begin
         scaled = shifted[IN_W-1:0];
      end
   end
endmodule : acc_scale
